// >>> hw/addr_decode_pkg.sv
// Package for the physical address decoder: region bounds, bank layouts, unit windows and the output carrier.
// Assumes a 32-bit physical address from the processor and one 200 MHz clock.
package addr_decode_pkg;

  // Mirror: only the low 29 address bits are decoded.
  localparam int MIRROR_BITS = 29;

  // Region bounds within the 512-Mbyte decoded space.
  localparam logic [28:0] ROM_LO = 29'h1800_0000;
  localparam logic [28:0] ISA_IO_LO = 29'h1400_0000;
  localparam logic [28:0] ISA_MEM_LO = 29'h1000_0000;
  localparam logic [28:0] RSV_HI_LO = 29'h0d00_0000;
  localparam logic [28:0] IO1_LO = 29'h0c00_0000;
  localparam logic [28:0] IO2_LO = 29'h0b00_0000;
  localparam logic [28:0] SHARED_LO = 29'h0a00_0000;
  localparam logic [28:0] RSV_LO_LO = 29'h0400_0000;

  // Unit windows are 32 bytes; space 1 has 4 windows, space 2 has 24.
  localparam int WIN_LSB = 5;
  localparam int IO1_UNITS = 4;
  localparam int IO2_UNITS = 24;
  localparam logic [23:0] IO2_LIVE = 24'hed_7bff;

  // External address pattern for the fast system bus memory space.
  localparam logic [1:0] FAST_BUS_TOP = 2'h2;
  localparam int EXT_ADDR_W = 26;

  // Bank bounds: four banks, entry k is bank k.
  typedef logic [3:0][31:0] bounds_t;

  // ROM layouts.
  localparam bounds_t ROM16_32M_LO = {32'h1fc0_0000, 32'h1f80_0000, 32'h1f40_0000, 32'h1f00_0000};
  localparam bounds_t ROM16_32M_HI = {32'h1fff_ffff, 32'h1fbf_ffff, 32'h1f7f_ffff, 32'h1f3f_ffff};
  localparam bounds_t ROM16_64M_LO = {32'h1f80_0000, 32'h1f00_0000, 32'h1e80_0000, 32'h1e00_0000};
  localparam bounds_t ROM16_64M_HI = {32'h1fff_ffff, 32'h1f7f_ffff, 32'h1eff_ffff, 32'h1e7f_ffff};
  localparam bounds_t ROM32_E0_32M_LO = {32'h1e80_0000, 32'h1e00_0000, 32'h1f80_0000, 32'h1f00_0000};
  localparam bounds_t ROM32_E0_32M_HI = {32'h1eff_ffff, 32'h1e7f_ffff, 32'h1fff_ffff, 32'h1f7f_ffff};
  localparam bounds_t ROM32_E0_64M_LO = {32'h1d80_0000, 32'h1d00_0000, 32'h1f00_0000, 32'h1e00_0000};
  localparam bounds_t ROM32_E0_64M_HI = {32'h1dff_ffff, 32'h1d7f_ffff, 32'h1fff_ffff, 32'h1eff_ffff};
  localparam bounds_t ROM32_E1_32M_LO = {32'h1e00_0000, 32'h1d00_0000, 32'h1f80_0000, 32'h1f00_0000};
  localparam bounds_t ROM32_E1_32M_HI = {32'h1eff_ffff, 32'h1dff_ffff, 32'h1fff_ffff, 32'h1f7f_ffff};
  localparam bounds_t ROM32_E1_64M_LO = {32'h1d00_0000, 32'h1c00_0000, 32'h1f00_0000, 32'h1e00_0000};
  localparam bounds_t ROM32_E1_64M_HI = {32'h1dff_ffff, 32'h1cff_ffff, 32'h1fff_ffff, 32'h1eff_ffff};

  // DRAM layouts.
  localparam bounds_t DRAM16_16M_LO = {32'h0060_0000, 32'h0040_0000, 32'h0020_0000, 32'h0000_0000};
  localparam bounds_t DRAM16_16M_HI = {32'h007f_ffff, 32'h005f_ffff, 32'h003f_ffff, 32'h001f_ffff};
  localparam bounds_t DRAM16_64M_LO = {32'h0180_0000, 32'h0100_0000, 32'h0080_0000, 32'h0000_0000};
  localparam bounds_t DRAM16_64M_HI = {32'h01ff_ffff, 32'h017f_ffff, 32'h00ff_ffff, 32'h007f_ffff};
  localparam bounds_t DRAM32_E0_16M_LO = {32'h00c0_0000, 32'h0080_0000, 32'h0040_0000, 32'h0000_0000};
  localparam bounds_t DRAM32_E0_16M_HI = {32'h00ff_ffff, 32'h00bf_ffff, 32'h007f_ffff, 32'h003f_ffff};
  localparam bounds_t DRAM32_E0_64M_LO = {32'h0240_0000, 32'h0200_0000, 32'h0100_0000, 32'h0000_0000};
  localparam bounds_t DRAM32_E0_64M_HI = {32'h027f_ffff, 32'h023f_ffff, 32'h01ff_ffff, 32'h00ff_ffff};
  localparam bounds_t DRAM32_E1_16M_LO = {32'h0200_0000, 32'h0100_0000, 32'h0040_0000, 32'h0000_0000};
  localparam bounds_t DRAM32_E1_16M_HI = {32'h027f_ffff, 32'h017f_ffff, 32'h007f_ffff, 32'h003f_ffff};
  localparam bounds_t DRAM32_E1_64M_LO = {32'h0300_0000, 32'h0280_0000, 32'h0100_0000, 32'h0000_0000};
  localparam bounds_t DRAM32_E1_64M_HI = {32'h03ff_ffff, 32'h02ff_ffff, 32'h027f_ffff, 32'h00ff_ffff};

  // Region that the latest address fell into.
  typedef enum logic [3:0] {
    REG_NONE, REG_DRAM, REG_SHARED_DISPLAY, REG_SHARED_FAST_BUS, REG_IO2, REG_IO1,
    REG_ISA_MEM, REG_ISA_IO, REG_ROM, REG_RESERVED
  } region_e;

  // Registered decode result.
  typedef struct packed {
    region_e region;
    logic [3:0] rom_bank_select_n;
    logic [3:0] mem_row_strobe_n;
    logic upper_low_col_strobe_n;
    logic upper_high_col_strobe_n;
    logic display_chip_select_n;
    logic [IO1_UNITS-1:0] io1_unit_sel;
    logic [IO2_UNITS-1:0] io2_unit_sel;
    logic [EXT_ADDR_W-1:0] ext_addr;
  } decode_s;

  // Display data path result.
  typedef struct packed {
    logic display_wide;
    logic [31:0] to_display;
    logic [31:0] to_cpu;
  } display_s;

endpackage

// >>> hw/physical_address_decoder.sv
// Physical address decoder: regions, ROM and DRAM bank selects, unit windows and display data path.
// Assumes the CPU presents a physical address with a valid strobe; strap pin is asynchronous.
`timescale 1ns/100ps

module physical_address_decoder import addr_decode_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // CPU address path.
  input wire logic addr_valid,
  input wire logic [31:0] phys_addr,
  // Strap pin and bus control bits.
  input wire logic wide_bus_strap,
  input wire logic rom_large_sel,
  input wire logic ext_rom_large_sel,
  input wire logic dram_large_sel,
  input wire logic ext_dram_large_sel,
  input wire logic bank23_dram_sel,
  input wire logic fast_bus_or_display_sel,
  input wire logic display_wide_sel,
  input wire logic display_data_invert,
  // Display data.
  input wire logic [31:0] cpu_wdata,
  input wire logic [31:0] display_rdata,
  // Decode results.
  output decode_s decode,
  output display_s display,
  output logic wide_bus
);

  // All module state.
  typedef struct packed {
    logic [2:0] strap_sync;
    logic wide;
    decode_s dec;
    display_s disp;
  } state_s;

  state_s state;
  state_s next_state;

  // One-hot bank match against four inclusive ranges.
  function automatic logic [3:0] bank_hit(input logic [31:0] a, input bounds_t lo, input bounds_t hi);
    logic [3:0] hit;
    hit = 4'h0;
    for (int k = 0; k < 4; k++) begin
      hit[k] = (a >= lo[k]) && (a <= hi[k]);
    end
    return hit;
  endfunction

  // Combined next-state logic.
  always_comb begin
    logic [28:0] a;
    logic [31:0] a32;
    logic [3:0] rom_hit;
    logic [3:0] dram_hit;
    logic [31:0] wmask;
    logic [31:0] inv;
    a = phys_addr[MIRROR_BITS-1:0];
    a32 = {3'h0, a};
    wmask = 32'h0000_0000;
    inv = 32'h0000_0000;
    rom_hit = 4'h0;
    dram_hit = 4'h0;
    next_state = state;
    // Strap pin crosses three flops; a change counts once stages two and three agree.
    next_state.strap_sync = {state.strap_sync[1:0], wide_bus_strap};
    if (state.strap_sync[2] == state.strap_sync[1]) begin
      next_state.wide = state.strap_sync[2];
    end
    // ROM bank layout choice.
    if (!state.wide) begin
      rom_hit = rom_large_sel ? bank_hit(a32, ROM16_64M_LO, ROM16_64M_HI)
                              : bank_hit(a32, ROM16_32M_LO, ROM16_32M_HI);
    end else if (!ext_rom_large_sel) begin
      rom_hit = rom_large_sel ? bank_hit(a32, ROM32_E0_64M_LO, ROM32_E0_64M_HI)
                              : bank_hit(a32, ROM32_E0_32M_LO, ROM32_E0_32M_HI);
    end else begin
      rom_hit = rom_large_sel ? bank_hit(a32, ROM32_E1_64M_LO, ROM32_E1_64M_HI)
                              : bank_hit(a32, ROM32_E1_32M_LO, ROM32_E1_32M_HI);
    end
    // DRAM bank layout choice.
    if (!state.wide) begin
      dram_hit = dram_large_sel ? bank_hit(a32, DRAM16_64M_LO, DRAM16_64M_HI)
                                : bank_hit(a32, DRAM16_16M_LO, DRAM16_16M_HI);
    end else if (!ext_dram_large_sel) begin
      dram_hit = dram_large_sel ? bank_hit(a32, DRAM32_E0_64M_LO, DRAM32_E0_64M_HI)
                                : bank_hit(a32, DRAM32_E0_16M_LO, DRAM32_E0_16M_HI);
    end else begin
      dram_hit = dram_large_sel ? bank_hit(a32, DRAM32_E1_64M_LO, DRAM32_E1_64M_HI)
                                : bank_hit(a32, DRAM32_E1_16M_LO, DRAM32_E1_16M_HI);
    end
    // Banks 2 and 3 belong to one use only in 32-bit modes.
    if (state.wide) begin
      if (bank23_dram_sel) begin
        rom_hit[3:2] = 2'h0;
      end else begin
        dram_hit[3:2] = 2'h0;
      end
    end
    // Idle outputs: nothing selected.
    next_state.dec.region = REG_NONE;
    next_state.dec.rom_bank_select_n = 4'hf;
    next_state.dec.mem_row_strobe_n = 4'hf;
    next_state.dec.upper_low_col_strobe_n = 1'b1;
    next_state.dec.upper_high_col_strobe_n = 1'b1;
    next_state.dec.display_chip_select_n = 1'b1;
    next_state.dec.io1_unit_sel = '0;
    next_state.dec.io2_unit_sel = '0;
    next_state.dec.ext_addr = a[EXT_ADDR_W-1:0];
    // Region decode, top down.
    if (addr_valid) begin
      if (a >= ROM_LO) begin
        next_state.dec.region = REG_ROM;
        next_state.dec.rom_bank_select_n = ~rom_hit;
      end else if (a >= ISA_IO_LO) begin
        next_state.dec.region = REG_ISA_IO;
      end else if (a >= ISA_MEM_LO) begin
        next_state.dec.region = REG_ISA_MEM;
      end else if (a >= RSV_HI_LO) begin
        next_state.dec.region = REG_RESERVED;
      end else if (a >= IO1_LO) begin
        next_state.dec.region = REG_IO1;
        if (a[23:WIN_LSB+2] == '0) begin
          next_state.dec.io1_unit_sel[a[WIN_LSB+1:WIN_LSB]] = 1'b1;
        end
      end else if (a >= IO2_LO) begin
        next_state.dec.region = REG_IO2;
        if (a[23:WIN_LSB] < 19'(IO2_UNITS)) begin
          next_state.dec.io2_unit_sel[a[WIN_LSB+4:WIN_LSB]] = IO2_LIVE[a[WIN_LSB+4:WIN_LSB]];
        end
      end else if (a >= SHARED_LO) begin
        next_state.dec.display_chip_select_n = 1'b0;
        if (fast_bus_or_display_sel) begin
          next_state.dec.region = REG_SHARED_FAST_BUS;
          next_state.dec.ext_addr = {FAST_BUS_TOP, a[23:0]};
        end else begin
          next_state.dec.region = REG_SHARED_DISPLAY;
        end
      end else if (a >= RSV_LO_LO) begin
        next_state.dec.region = REG_RESERVED;
      end else begin
        next_state.dec.region = REG_DRAM;
        next_state.dec.mem_row_strobe_n = ~dram_hit;
        if (state.wide) begin
          next_state.dec.mem_row_strobe_n[3:2] = 2'h3;
          next_state.dec.rom_bank_select_n[3:2] = ~dram_hit[3:2];
        end else begin
          next_state.dec.upper_low_col_strobe_n = ~dram_hit[2];
          next_state.dec.upper_high_col_strobe_n = ~dram_hit[3];
        end
      end
    end
    // Display data path: width and optional inversion.
    next_state.disp.display_wide = state.wide && display_wide_sel;
    wmask = next_state.disp.display_wide ? 32'hffff_ffff : 32'h0000_ffff;
    inv = display_data_invert ? wmask : 32'h0000_0000;
    next_state.disp.to_display = (cpu_wdata ^ inv) & wmask;
    next_state.disp.to_cpu = (display_rdata ^ inv) & wmask;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state.strap_sync <= 3'h0;
      state.wide <= 1'b0;
      state.dec.region <= REG_NONE;
      state.dec.rom_bank_select_n <= 4'hf;
      state.dec.mem_row_strobe_n <= 4'hf;
      state.dec.upper_low_col_strobe_n <= 1'b1;
      state.dec.upper_high_col_strobe_n <= 1'b1;
      state.dec.display_chip_select_n <= 1'b1;
      state.dec.io1_unit_sel <= '0;
      state.dec.io2_unit_sel <= '0;
      state.dec.ext_addr <= '0;
      state.disp <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register.
  assign decode = state.dec;
  assign display = state.disp;
  assign wide_bus = state.wide;

endmodule

// >>> test/display_ctrl_model.sv
// Model of the external display controller read data.
// Assumes it watches the decoder's display chip select.
`timescale 1ns/100ps
module display_ctrl_model (
  // Clock and select.
  input wire logic clk,
  input wire logic display_chip_select_n,
  // Read data back to the decoder.
  output logic [31:0] display_rdata
);
  // Fresh data while selected; a released bus shows the inverse of its last value.
  initial display_rdata = 32'h0;
  always @(posedge clk) begin
    if (!display_chip_select_n) begin
      display_rdata <= $urandom;
    end else begin
      display_rdata <= ~display_rdata;
    end
  end
endmodule

// >>> test/physical_address_decoder_monitor.sv
// Checker for the address decoder, bound to its top module ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
module physical_address_decoder_monitor import addr_decode_pkg::*; (
  // Clock, reset and inputs.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic addr_valid,
  input wire logic [31:0] phys_addr,
  input wire logic fast_bus_or_display_sel,
  input wire logic display_wide_sel,
  input wire logic display_data_invert,
  input wire logic [31:0] cpu_wdata,
  // Outputs.
  input wire decode_s decode,
  input wire display_s display,
  input wire logic wide_bus
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] aq;
  logic [31:0] wq;
  // Keeps last address and the narrow display data it should produce.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aq <= 32'h0;
      wq <= 32'h0;
    end else begin
      aq <= phys_addr;
      wq <= cpu_wdata ^ {32{display_data_invert}};
    end
  end
  // Top 4 Mbytes of ROM hold a bank in every layout; shared space is one 16-Mbyte block.
  sequence s_top; addr_valid && phys_addr[28:22] == 7'h7f; endsequence
  sequence s_shr; addr_valid && phys_addr[28:24] == 5'h0a; endsequence
  property p_rom; s_top |=> decode.region == REG_ROM && $countones(~decode.rom_bank_select_n) == 1; endproperty
  property p_radr; s_top |=> decode.ext_addr == aq[25:0]; endproperty
  property p_isa; addr_valid && phys_addr[28:27] == 2'h2 |=> decode.region == (aq[26] ? REG_ISA_IO : REG_ISA_MEM);
  endproperty
  property p_fast; s_shr ##0 fast_bus_or_display_sel |=> decode.ext_addr[25:24] == FAST_BUS_TOP; endproperty
  property p_dcs; s_shr |=> !decode.display_chip_select_n; endproperty
  property p_rsv; addr_valid && phys_addr[28:24] inside {5'h0d, 5'h0e, 5'h0f}
    |=> &{decode.rom_bank_select_n, decode.mem_row_strobe_n, decode.display_chip_select_n}; endproperty
  property p_excl; (decode.rom_bank_select_n[3:2] | decode.mem_row_strobe_n[3:2]) == 2'h3; endproperty
  property p_io1; addr_valid && phys_addr[28:7] == 22'h18_0000 |=> decode.io1_unit_sel == 4'h1 << aq[6:5];
  endproperty
  property p_wide; display.display_wide == ($past(wide_bus) && $past(display_wide_sel)); endproperty
  property p_narw; !display.display_wide |-> display.to_display == {16'h0, wq[15:0]}; endproperty
  // Assertions on the registered outputs.
  a_rom: assert property (p_rom) else $error("top ROM access without one bank select");
  a_radr: assert property (p_radr) else $error("ROM external address wrong");
  a_isa: assert property (p_isa) else $error("system bus region wrong");
  a_fast: assert property (p_fast) else $error("fast bus address top bits wrong");
  a_dcs: assert property (p_dcs) else $error("display select missing");
  a_rsv: assert property (p_rsv) else $error("select in reserved space");
  a_excl: assert property (p_excl) else $error("bank 2 or 3 used twice");
  a_io1: assert property (p_io1) else $error("space 1 window select wrong");
  a_wide: assert property (p_wide) else $error("display width wrong");
  a_narw: assert property (p_narw) else $error("narrow display data wrong");
endmodule
bind physical_address_decoder physical_address_decoder_monitor physical_address_decoder_monitor_inst (.clk, .rst_n,
  .addr_valid, .phys_addr, .fast_bus_or_display_sel, .display_wide_sel, .display_data_invert, .cpu_wdata, .decode,
  .display, .wide_bus);

// >>> test/physical_address_decoder_test.sv
// Self-checking bench for the physical address decoder.
// Assumes the decoder package and the display controller model.
`timescale 1ns/100ps
module physical_address_decoder_test import addr_decode_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic addr_valid, wide_bus_strap, rom_large_sel, ext_rom_large_sel, dram_large_sel, ext_dram_large_sel, eh, ew;
  logic bank23_dram_sel, fast_bus_or_display_sel, display_wide_sel, display_data_invert, wide_bus, pend;
  logic [31:0] phys_addr, cpu_wdata, display_rdata, a;
  logic [31:0] fixed [6] = '{32'h3fc0_0000, 32'hffff_ffff, 32'h0d00_0000, 32'h0c00_0080, 32'h0aff_ffff, 32'h0400_0000};
  decode_s decode, ed;
  display_s display, ep;
  int err_total = 0;
  int samples_checked = 0;
  // Clock with a 5 ns period.
  always #2.5 clk = ~clk;
  physical_address_decoder physical_address_decoder_inst (.clk, .rst_n, .addr_valid, .phys_addr, .wide_bus_strap,
    .rom_large_sel, .ext_rom_large_sel, .dram_large_sel, .ext_dram_large_sel, .bank23_dram_sel,
    .fast_bus_or_display_sel, .display_wide_sel, .display_data_invert, .cpu_wdata, .display_rdata, .decode,
    .display, .wide_bus);
  display_ctrl_model display_ctrl_model_inst (.clk, .display_chip_select_n(decode.display_chip_select_n),
    .display_rdata);
  // Expected decode; hit is low where a reserved slot leaves the region open.
  function automatic decode_s model(logic [28:0] m, logic v, output logic hit);
    decode_s d;
    bounds_t lo;
    bounds_t hi;
    logic w;
    logic r;
    d = '0;
    {d.rom_bank_select_n, d.mem_row_strobe_n, d.upper_low_col_strobe_n, d.upper_high_col_strobe_n} = '1;
    d.display_chip_select_n = 1'b1;
    hit = 1'b1;
    d.ext_addr = m[25:0];
    if (!v) return d;
    if (m >= ROM_LO) d.region = REG_ROM;
    else if (m >= ISA_IO_LO) d.region = REG_ISA_IO;
    else if (m >= ISA_MEM_LO) d.region = REG_ISA_MEM;
    else if (m >= RSV_HI_LO) d.region = REG_RESERVED;
    else if (m >= IO1_LO) d.region = REG_IO1;
    else if (m >= IO2_LO) d.region = REG_IO2;
    else if (m >= SHARED_LO) d.region = fast_bus_or_display_sel ? REG_SHARED_FAST_BUS : REG_SHARED_DISPLAY;
    else if (m >= RSV_LO_LO) d.region = REG_RESERVED;
    else d.region = REG_DRAM;
    w = wide_bus_strap;
    r = d.region == REG_DRAM;
    lo = '1;
    hi = '0;
    case ({r, w, w & (r ? ext_dram_large_sel : ext_rom_large_sel), r ? dram_large_sel : rom_large_sel})
      4'h0: {lo, hi} = {ROM16_32M_LO, ROM16_32M_HI};
      4'h1: {lo, hi} = {ROM16_64M_LO, ROM16_64M_HI};
      4'h4: {lo, hi} = {ROM32_E0_32M_LO, ROM32_E0_32M_HI};
      4'h5: {lo, hi} = {ROM32_E0_64M_LO, ROM32_E0_64M_HI};
      4'h6: {lo, hi} = {ROM32_E1_32M_LO, ROM32_E1_32M_HI};
      4'h7: {lo, hi} = {ROM32_E1_64M_LO, ROM32_E1_64M_HI};
      4'h8: {lo, hi} = {DRAM16_16M_LO, DRAM16_16M_HI};
      4'h9: {lo, hi} = {DRAM16_64M_LO, DRAM16_64M_HI};
      4'hc: {lo, hi} = {DRAM32_E0_16M_LO, DRAM32_E0_16M_HI};
      4'hd: {lo, hi} = {DRAM32_E0_64M_LO, DRAM32_E0_64M_HI};
      4'he: {lo, hi} = {DRAM32_E1_16M_LO, DRAM32_E1_16M_HI};
      4'hf: {lo, hi} = {DRAM32_E1_64M_LO, DRAM32_E1_64M_HI};
      default: ;
    endcase
    for (int k = 0; k < 4; k++) begin
      if (d.region inside {REG_ROM, REG_DRAM} && m >= lo[k][28:0] && m <= hi[k][28:0]) begin
        if (!r) d.rom_bank_select_n[k] = w && k > 1 && bank23_dram_sel;
        else if (!w || k < 2) d.mem_row_strobe_n[k] = 1'b0;
        else d.rom_bank_select_n[k] = !bank23_dram_sel;
        if (r && !w && k == 2) d.upper_low_col_strobe_n = 1'b0;
        if (r && !w && k == 3) d.upper_high_col_strobe_n = 1'b0;
      end
    end
    if (d.region == REG_SHARED_FAST_BUS) d.ext_addr[25:24] = FAST_BUS_TOP;
    if (d.region inside {REG_SHARED_FAST_BUS, REG_SHARED_DISPLAY}) d.display_chip_select_n = 1'b0;
    if (d.region == REG_IO1 && m[23:7] == 0) d.io1_unit_sel[m[6:5]] = 1'b1;
    if (d.region == REG_IO2 && m[23:10] == 0 && m[9:5] < 24) d.io2_unit_sel[m[9:5]] = IO2_LIVE[m[9:5]];
    hit = !(d.region inside {REG_ROM, REG_DRAM, REG_IO1, REG_IO2}) || d.rom_bank_select_n != 4'hf ||
      d.mem_row_strobe_n != 4'hf || |{d.io1_unit_sel, d.io2_unit_sel};
    return d;
  endfunction
  // Compares a decode result; region is left out for open reserved slots.
  task automatic cmp_dec(decode_s g, decode_s e, logic h);
    samples_checked++;
    if (!h) g.region = e.region;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Compares the display path and the filtered strap.
  task automatic cmp_disp(logic [65:0] g, logic [65:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Checks the previous cycle, then drives one request at the falling edge.
  task automatic step(logic [31:0] ad, logic v);
    logic [31:0] mk;
    @(negedge clk);
    if (pend) cmp_dec(decode, ed, eh);
    if (pend) cmp_disp({display, wide_bus}, {ep, ew});
    addr_valid = v;
    phys_addr = ad;
    bank23_dram_sel = 1'($urandom);
    fast_bus_or_display_sel = 1'($urandom);
    display_wide_sel = 1'($urandom);
    display_data_invert = 1'($urandom);
    cpu_wdata = $urandom;
    ed = model(ad[28:0], v, eh);
    mk = (wide_bus_strap && display_wide_sel) ? 32'hffff_ffff : 32'h0000_ffff;
    ep = '{wide_bus_strap && display_wide_sel, (cpu_wdata ^ {32{display_data_invert}}) & mk,
      (display_rdata ^ {32{display_data_invert}}) & mk};
    ew = wide_bus_strap;
    pend = 1'b1;
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence: every strap and capacity setting with edge and random addresses.
  initial begin
    {addr_valid, wide_bus_strap, rom_large_sel, ext_rom_large_sel, dram_large_sel, ext_dram_large_sel} = '0;
    {bank23_dram_sel, fast_bus_or_display_sel, display_wide_sel, display_data_invert, pend} = '0;
    {phys_addr, cpu_wdata} = '0;
    void'($urandom(28267));
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int c = 0; c < 32; c++) begin
      pend = 1'b0;
      {ext_dram_large_sel, dram_large_sel, ext_rom_large_sel, rom_large_sel, wide_bus_strap} = 5'(c);
      repeat (6) @(negedge clk);
      foreach (fixed[i]) step(fixed[i], 1'b1);
      repeat (120) begin
        a = $urandom;
        case (a[1:0])
          2'h0: a[28:27] = 2'h3;
          2'h1: a[28:26] = 3'h0;
          2'h2: a[28:10] = {5'h0b + 5'(a[10]), 14'h0};
          default: ;
        endcase
        if (a[1:0] < 2 && a[2]) a[20:0] = a[3] ? 21'h1f_ffff : 21'h0;
        step(a, a[4] | a[5]);
      end
      $display("setting %0d done, %0d checks", c, samples_checked);
    end
    conclude();
  end
  // Watchdog against a hang.
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule
